// file: src/latency_path_pkg.sv
// Purpose: shared types and timing constants for the copper/serial latency datapath
// Assumes: one 100 MHz clock; all times in ns, counts derived from them
// Notes:   bounds hold with the latency field at 00; each step adds a per-speed amount
package latency_path_pkg;

	localparam int CLK_PERIOD_NS = 10;

	typedef struct packed {
		logic       sop;
		logic       eop;
		logic [7:0] data;
	} stream_word_type;

	typedef enum logic [1:0] {SPEED_10, SPEED_100, SPEED_1000} speed_type;
	typedef enum logic [1:0] {NIB_HUNT, NIB_LOW, NIB_HIGH} nibble_state_type;

	// copper to single serial link
	localparam int CU_TO_SGMII_1000_MIN_NS = 292;
	localparam int CU_TO_SGMII_1000_MAX_NS = 336;
	localparam int CU_TO_SGMII_100_MIN_NS  = 620;
	localparam int CU_TO_SGMII_100_MAX_NS  = 732;
	localparam int CU_TO_SGMII_10_MIN_NS   = 4817;
	localparam int CU_TO_SGMII_10_MAX_NS   = 5603;
	// single serial link to copper
	localparam int SGMII_TO_CU_1000_MIN_NS = 192;
	localparam int SGMII_TO_CU_1000_MAX_NS = 216;
	localparam int SGMII_TO_CU_100_MIN_NS  = 528;
	localparam int SGMII_TO_CU_100_MAX_NS  = 612;
	localparam int SGMII_TO_CU_10_MIN_NS   = 3822;
	localparam int SGMII_TO_CU_10_MAX_NS   = 4634;
	// copper to quad serial link
	localparam int CU_TO_QUAD_1000_MIN_NS  = 308;
	localparam int CU_TO_QUAD_1000_MAX_NS  = 356;
	localparam int CU_TO_QUAD_100_MIN_NS   = 628;
	localparam int CU_TO_QUAD_100_MAX_NS   = 744;
	localparam int CU_TO_QUAD_10_MIN_NS    = 4825;
	localparam int CU_TO_QUAD_10_MAX_NS    = 5615;
	// quad serial link to copper
	localparam int QUAD_TO_CU_1000_MIN_NS  = 222;
	localparam int QUAD_TO_CU_1000_MAX_NS  = 250;
	localparam int QUAD_TO_CU_100_MIN_NS   = 506;
	localparam int QUAD_TO_CU_100_MAX_NS   = 614;
	localparam int QUAD_TO_CU_10_MIN_NS    = 3827;
	localparam int QUAD_TO_CU_10_MAX_NS    = 4644;

	// added delay per latency field step
	localparam int STEP_1000_NS = 8;
	localparam int STEP_100_NS  = 40;
	localparam int STEP_10_NS   = 400;

	// fixed register stages around the delay line, in cycles
	localparam int RX_PIPE_CYCLES = 3;
	localparam int TX_PIPE_CYCLES = 2;

	localparam logic [3:0]  SFD_NIBBLE      = 4'hd;
	localparam logic [3:0]  PAIRS_ALL       = 4'hf;
	localparam logic [1:0]  LAT_FIELD_RESET = 2'h0;
	localparam int          DLY_AW_DEFAULT  = 10;

	// least delay rounds up to whole cycles
	function automatic int lat_cycles(input int min_ns, input int field, input int step_ns);
		return (min_ns + field * step_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction

endpackage

// file: src/latency_delay_line.sv
// Purpose: circular-buffer delay line with a run-time selectable depth
// Assumes: 1 <= i_delay < 2**AW; output masked until the buffer has wrapped once
// Notes:   latency from a write edge to the output edge is i_delay enabled cycles
`timescale 1ns/1ns
module latency_delay_line #(
	parameter int WIDTH = 11,
	parameter int AW    = 10
) (
	input  wire logic             i_sys_clk, // system clock
	input  wire logic             i_rst_b,   // async reset, active low
	input  wire logic             i_en,      // advance one step
	input  wire logic [AW-1:0]    i_delay,   // depth in cycles
	input  wire logic [WIDTH-1:0] i_data,    // word written this step
	output logic      [WIDTH-1:0] o_data     // word from i_delay steps ago
);
	logic [WIDTH-1:0] mem [2**AW];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    wr_ptr_next;
	logic [WIDTH-1:0] out_reg;
	logic [WIDTH-1:0] out_next;
	logic             primed_reg;
	logic             primed_next;

	always_comb begin
		wr_ptr_next = wr_ptr_reg;
		out_next    = out_reg;
		primed_next = primed_reg;
		if (i_en) begin
			wr_ptr_next = wr_ptr_reg + 1'b1;
			// stale memory after reset must not look like traffic
			out_next = primed_reg ? mem[wr_ptr_reg - i_delay] : '0;
			if (&wr_ptr_reg) begin
				primed_next = 1'b1;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_en) begin
			mem[wr_ptr_reg] <= i_data;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ptr_reg <= '0;
			out_reg    <= '0;
			primed_reg <= 1'b0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			out_reg    <= out_next;
			primed_reg <= primed_next;
		end
	end

	assign o_data = out_reg;
endmodule

// file: src/two_entry_buffer.sv
// Purpose: two-entry valid/ready buffer so a stalled receiver loses no word
// Assumes: i_ce freezes all state
// Notes:   all outputs are flops; one cycle from push to output valid
`timescale 1ns/1ns
module two_entry_buffer #(
	parameter int WIDTH = 10
) (
	input  wire logic             i_sys_clk,   // system clock
	input  wire logic             i_rst_b,     // async reset, active low
	input  wire logic             i_ce,        // clock enable
	input  wire logic             i_in_valid,  // word offered
	input  wire logic [WIDTH-1:0] i_in_data,   // offered word
	output logic                  o_in_ready,  // room for a word
	output logic                  o_out_valid, // head word valid
	output logic      [WIDTH-1:0] o_out_data,  // head word
	input  wire logic             i_out_ready  // receiver takes head
);
	logic [WIDTH-1:0] slot0_reg, slot0_next;
	logic [WIDTH-1:0] slot1_reg, slot1_next;
	logic [1:0]       count_reg, count_next;
	logic             valid_reg, valid_next;
	logic             ready_reg, ready_next;

	always_comb begin
		slot0_next = slot0_reg;
		slot1_next = slot1_reg;
		count_next = count_reg;
		if (i_ce && valid_reg && i_out_ready) begin
			slot0_next = slot1_reg;
			count_next = count_next - 2'd1;
		end
		if (i_ce && i_in_valid && ready_reg) begin
			if (count_next == 2'd0) begin
				slot0_next = i_in_data;
			end else begin
				slot1_next = i_in_data;
			end
			count_next = count_next + 2'd1;
		end
		valid_next = (count_next != 2'd0);
		ready_next = (count_next != 2'd2);
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			slot0_reg <= '0;
			slot1_reg <= '0;
			count_reg <= 2'd0;
			valid_reg <= 1'b0;
			ready_reg <= 1'b1;
		end else begin
			slot0_reg <= slot0_next;
			slot1_reg <= slot1_next;
			count_reg <= count_next;
			valid_reg <= valid_next;
			ready_reg <= ready_next;
		end
	end

	assign o_in_ready  = ready_reg;
	assign o_out_valid = valid_reg;
	assign o_out_data  = slot0_reg;
endmodule

// file: src/copper_serdes_path_latency.sv
// Purpose: copper <-> serial link packet datapath with bounded, programmable latency
// Assumes: all stream inputs are logic on i_sys_clk; configuration held steady in a frame
// Notes:   one delay line per direction sets the latency; stalls by a receiver stretch it
`timescale 1ns/1ns
module copper_serdes_path_latency
	#(
	parameter int DLY_AW = latency_path_pkg::DLY_AW_DEFAULT
) (
	input  wire logic                              i_sys_clk,                   // 100 MHz clock
	input  wire logic                              i_rst_b,                     // async reset, low
	input  wire logic                              i_ce,                        // clock enable
	input  wire latency_path_pkg::speed_type       i_speed,                     // link speed
	input  wire logic                              i_quad_mode,                 // 1: quad link
	input  wire logic [1:0]                        i_rx_lat_field,              // copper->serial
	input  wire logic [1:0]                        i_tx_lat_field,              // serial->copper
	input  wire logic                              i_copper_media_pairs_valid,  // copper word
	input  wire latency_path_pkg::stream_word_type i_copper_media_pairs_word,   // copper data
	input  wire logic [3:0]                        i_copper_pair_start,         // per-pair start
	output logic                                   o_copper_media_pairs_ready,  // copper taken
	output logic                                   o_sgmii_tx_pair_valid,       // single link out
	output latency_path_pkg::stream_word_type      o_sgmii_tx_pair_word,        // single link data
	input  wire logic                              i_sgmii_tx_pair_ready,       // single link takes
	output logic                                   o_quad_serial_tx_pair_valid, // quad link out
	output latency_path_pkg::stream_word_type      o_quad_serial_tx_pair_word,  // quad link data
	input  wire logic                              i_quad_serial_tx_pair_ready, // quad link takes
	input  wire logic                              i_sgmii_rx_pair_valid,       // single link in
	input  wire latency_path_pkg::stream_word_type i_sgmii_rx_pair_word,        // single link data
	input  wire logic                              i_quad_serial_rx_pair_valid, // quad link in
	input  wire latency_path_pkg::stream_word_type i_quad_serial_rx_pair_word,  // quad link data
	output logic                                   o_serial_rx_ready,           // serial in taken
	output logic                                   o_copper_tx_valid,           // copper out
	output latency_path_pkg::stream_word_type      o_copper_tx_word,            // copper out data
	input  wire logic                              i_copper_tx_ready            // copper takes
);
	import latency_path_pkg::*;

	localparam int WW = $bits(stream_word_type);

	// delay selection
	int                min_rx_ns;
	int                min_tx_ns;
	int                step_ns;
	logic [DLY_AW-1:0] rx_delay;
	logic [DLY_AW-1:0] tx_delay;

	// copper front end
	logic              rx_en;
	logic              fe_valid_reg, fe_valid_next;
	stream_word_type   fe_word_reg, fe_word_next;
	logic [3:0]        pairs_seen_reg, pairs_seen_next;
	logic [3:0]        pairs_now;
	logic              sop_pend_reg, sop_pend_next;
	logic              aligned_now;
	nibble_state_type  nib_state_reg, nib_state_next;
	logic [3:0]        low_nib_reg, low_nib_next;
	logic              first_byte_reg, first_byte_next;

	// copper to serial path
	logic [WW:0]       rx_dl_out;
	logic              rx_buf_ready;
	logic              rx_buf_valid;
	logic [WW-1:0]     rx_buf_data;
	logic              rx_buf_take;
	logic              sg_valid_reg, sg_valid_next;
	logic              qd_valid_reg, qd_valid_next;
	stream_word_type   ser_out_reg, ser_out_next;

	// serial to copper path
	logic              tx_en;
	logic              tx_buf_ready;
	logic              si_valid_reg, si_valid_next;
	stream_word_type   si_word_reg, si_word_next;
	logic [WW:0]       tx_dl_out;
	logic [WW-1:0]     tx_buf_data;

	// per-speed base delay and step, by direction and link kind
	always_comb begin
		case (i_speed)
			SPEED_1000: begin
				step_ns = STEP_1000_NS;
				min_rx_ns = i_quad_mode ? CU_TO_QUAD_1000_MIN_NS : CU_TO_SGMII_1000_MIN_NS;
				min_tx_ns = i_quad_mode ? QUAD_TO_CU_1000_MIN_NS : SGMII_TO_CU_1000_MIN_NS;
			end
			SPEED_100: begin
				step_ns = STEP_100_NS;
				min_rx_ns = i_quad_mode ? CU_TO_QUAD_100_MIN_NS : CU_TO_SGMII_100_MIN_NS;
				min_tx_ns = i_quad_mode ? QUAD_TO_CU_100_MIN_NS : SGMII_TO_CU_100_MIN_NS;
			end
			default: begin
				step_ns = STEP_10_NS;
				min_rx_ns = i_quad_mode ? CU_TO_QUAD_10_MIN_NS : CU_TO_SGMII_10_MIN_NS;
				min_tx_ns = i_quad_mode ? QUAD_TO_CU_10_MIN_NS : SGMII_TO_CU_10_MIN_NS;
			end
		endcase
	end

	assign rx_delay = DLY_AW'(lat_cycles(min_rx_ns, int'(i_rx_lat_field), step_ns)
		- RX_PIPE_CYCLES);
	assign tx_delay = DLY_AW'(lat_cycles(min_tx_ns, int'(i_tx_lat_field), step_ns)
		- TX_PIPE_CYCLES);

	// the receive front end and delay line move only while their buffer has room
	assign rx_en = i_ce & rx_buf_ready;
	assign tx_en = i_ce & tx_buf_ready;

	// copper front end: start marking and nibble assembly
	always_comb begin
		fe_valid_next   = fe_valid_reg;
		fe_word_next    = fe_word_reg;
		pairs_seen_next = pairs_seen_reg;
		sop_pend_next   = sop_pend_reg;
		nib_state_next  = nib_state_reg;
		low_nib_next    = low_nib_reg;
		first_byte_next = first_byte_reg;
		pairs_now       = pairs_seen_reg | i_copper_pair_start;
		aligned_now     = (pairs_now == PAIRS_ALL) && (pairs_seen_reg != PAIRS_ALL);
		if (rx_en) begin
			fe_valid_next = 1'b0;
			case (i_speed)
				SPEED_1000: begin
					pairs_seen_next = pairs_now;
					if (aligned_now) begin
						sop_pend_next = 1'b1;
					end
					if (i_copper_media_pairs_valid) begin
						fe_valid_next    = 1'b1;
						fe_word_next     = i_copper_media_pairs_word;
						fe_word_next.sop = sop_pend_reg | aligned_now;
						sop_pend_next    = 1'b0;
						if (i_copper_media_pairs_word.eop) begin
							pairs_seen_next = '0;
						end
					end
				end
				SPEED_100: begin
					if (i_copper_media_pairs_valid) begin
						fe_valid_next = 1'b1;
						fe_word_next  = i_copper_media_pairs_word;
					end
				end
				default: begin
					if (i_copper_media_pairs_valid) begin
						if (i_copper_media_pairs_word.eop) begin
							// a half byte still held here is dribble and is dropped
							fe_valid_next  = 1'b1;
							fe_word_next   = '{sop: 1'b0, eop: 1'b1, data: 8'h00};
							nib_state_next = NIB_HUNT;
						end else begin
							case (nib_state_reg)
								NIB_HUNT: begin
									if (i_copper_media_pairs_word.data[3:0] == SFD_NIBBLE) begin
										nib_state_next  = NIB_LOW;
										first_byte_next = 1'b1;
									end
								end
								NIB_LOW: begin
									low_nib_next   = i_copper_media_pairs_word.data[3:0];
									nib_state_next = NIB_HIGH;
								end
								NIB_HIGH: begin
									fe_valid_next   = 1'b1;
									fe_word_next    = '{sop: first_byte_reg, eop: 1'b0,
										data: {i_copper_media_pairs_word.data[3:0], low_nib_reg}};
									first_byte_next = 1'b0;
									nib_state_next  = NIB_LOW;
								end
								default: begin
									nib_state_next = NIB_HUNT;
								end
							endcase
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fe_valid_reg   <= 1'b0;
			fe_word_reg    <= '0;
			pairs_seen_reg <= '0;
			sop_pend_reg   <= 1'b0;
			nib_state_reg  <= NIB_HUNT;
			low_nib_reg    <= '0;
			first_byte_reg <= 1'b0;
		end else begin
			fe_valid_reg   <= fe_valid_next;
			fe_word_reg    <= fe_word_next;
			pairs_seen_reg <= pairs_seen_next;
			sop_pend_reg   <= sop_pend_next;
			nib_state_reg  <= nib_state_next;
			low_nib_reg    <= low_nib_next;
			first_byte_reg <= first_byte_next;
		end
	end

	latency_delay_line #(
		.WIDTH (WW + 1),
		.AW    (DLY_AW)
	) u_rx_delay (
		.i_sys_clk (i_sys_clk),
		.i_rst_b   (i_rst_b),
		.i_en      (rx_en),
		.i_delay   (rx_delay),
		.i_data    ({fe_valid_reg, fe_word_reg}),
		.o_data    (rx_dl_out)
	);

	two_entry_buffer #(
		.WIDTH (WW)
	) u_rx_buf (
		.i_sys_clk   (i_sys_clk),
		.i_rst_b     (i_rst_b),
		.i_ce        (i_ce),
		.i_in_valid  (rx_dl_out[WW]),
		.i_in_data   (rx_dl_out[WW-1:0]),
		.o_in_ready  (rx_buf_ready),
		.o_out_valid (rx_buf_valid),
		.o_out_data  (rx_buf_data),
		.i_out_ready (rx_buf_take)
	);

	// output stage steers the word to the selected serial link
	assign rx_buf_take = (~sg_valid_reg & ~qd_valid_reg)
		| (sg_valid_reg & i_sgmii_tx_pair_ready)
		| (qd_valid_reg & i_quad_serial_tx_pair_ready);

	always_comb begin
		sg_valid_next = sg_valid_reg;
		qd_valid_next = qd_valid_reg;
		ser_out_next  = ser_out_reg;
		if (i_ce) begin
			if (sg_valid_reg && i_sgmii_tx_pair_ready) begin
				sg_valid_next = 1'b0;
			end
			if (qd_valid_reg && i_quad_serial_tx_pair_ready) begin
				qd_valid_next = 1'b0;
			end
			if (rx_buf_valid && rx_buf_take) begin
				ser_out_next  = stream_word_type'(rx_buf_data);
				sg_valid_next = ~i_quad_mode;
				qd_valid_next = i_quad_mode;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sg_valid_reg <= 1'b0;
			qd_valid_reg <= 1'b0;
			ser_out_reg  <= '0;
		end else begin
			sg_valid_reg <= sg_valid_next;
			qd_valid_reg <= qd_valid_next;
			ser_out_reg  <= ser_out_next;
		end
	end

	// serial input stage picks the active link
	always_comb begin
		si_valid_next = si_valid_reg;
		si_word_next  = si_word_reg;
		if (tx_en) begin
			if (i_quad_mode) begin
				si_valid_next = i_quad_serial_rx_pair_valid;
				si_word_next  = i_quad_serial_rx_pair_word;
			end else begin
				si_valid_next = i_sgmii_rx_pair_valid;
				si_word_next  = i_sgmii_rx_pair_word;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			si_valid_reg <= 1'b0;
			si_word_reg  <= '0;
		end else begin
			si_valid_reg <= si_valid_next;
			si_word_reg  <= si_word_next;
		end
	end

	latency_delay_line #(
		.WIDTH (WW + 1),
		.AW    (DLY_AW)
	) u_tx_delay (
		.i_sys_clk (i_sys_clk),
		.i_rst_b   (i_rst_b),
		.i_en      (tx_en),
		.i_delay   (tx_delay),
		.i_data    ({si_valid_reg, si_word_reg}),
		.o_data    (tx_dl_out)
	);

	two_entry_buffer #(
		.WIDTH (WW)
	) u_tx_buf (
		.i_sys_clk   (i_sys_clk),
		.i_rst_b     (i_rst_b),
		.i_ce        (i_ce),
		.i_in_valid  (tx_dl_out[WW]),
		.i_in_data   (tx_dl_out[WW-1:0]),
		.o_in_ready  (tx_buf_ready),
		.o_out_valid (o_copper_tx_valid),
		.o_out_data  (tx_buf_data),
		.i_out_ready (i_copper_tx_ready)
	);

	assign o_copper_tx_word            = stream_word_type'(tx_buf_data);
	assign o_copper_media_pairs_ready  = rx_buf_ready;
	assign o_serial_rx_ready           = tx_buf_ready;
	assign o_sgmii_tx_pair_valid       = sg_valid_reg;
	assign o_quad_serial_tx_pair_valid = qd_valid_reg;
	assign o_sgmii_tx_pair_word        = ser_out_reg;
	assign o_quad_serial_tx_pair_word  = ser_out_reg;

endmodule

// file: testbench/mac_link_model.sv
// Purpose: far-side link receiver that takes words from the serial outputs
// Assumes: shares the system clock, so the two sides have no frequency drift
// Notes:   stalls follow a pseudo-random pattern while enabled
`timescale 1ns/1ns
module mac_link_model (
	input  wire logic i_sys_clk,     // clock
	input  wire logic i_rst_b,       // reset, low
	input  wire logic i_stall_en,    // allow stalls
	output logic      o_sgmii_ready, // single link takes
	output logic      o_quad_ready   // quad link takes
);
	logic [7:0] pat_reg;
	logic [7:0] pat_next;

	always_comb begin
		pat_next = {pat_reg[6:0], pat_reg[7] ^ pat_reg[5] ^ pat_reg[4] ^ pat_reg[3]};
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pat_reg <= 8'h5a;
		end else begin
			pat_reg <= pat_next;
		end
	end

	assign o_sgmii_ready = !i_stall_en || pat_reg[0];
	assign o_quad_ready  = !i_stall_en || pat_reg[1];
endmodule

// file: testbench/latency_path_sva.sv
// Purpose: port-level checks of the latency datapath
// Assumes: latency figures hold at field 00 with no stall
// Notes:   bound into the top module
`timescale 1ns/1ns
module latency_path_sva
	import latency_path_pkg::*;
(
	input wire logic            i_sys_clk,                   // clock
	input wire logic            i_rst_b,                     // reset, low
	input wire logic            i_ce,                        // enable
	input wire speed_type       i_speed,                     // speed
	input wire logic            i_quad_mode,                 // quad link
	input wire logic [1:0]      i_rx_lat_field,              // rx field
	input wire logic [1:0]      i_tx_lat_field,              // tx field
	input wire logic            i_copper_media_pairs_valid,  // copper in
	input wire logic            o_copper_media_pairs_ready,  // copper taken
	input wire logic            o_sgmii_tx_pair_valid,       // single out
	input wire stream_word_type o_sgmii_tx_pair_word,        // single data
	input wire logic            i_sgmii_tx_pair_ready,       // single takes
	input wire logic            o_quad_serial_tx_pair_valid, // quad out
	input wire logic            i_sgmii_rx_pair_valid,       // single in
	input wire logic            i_quad_serial_rx_pair_valid, // quad in
	input wire logic            o_serial_rx_ready,           // serial taken
	input wire logic            o_copper_tx_valid,           // copper out
	input wire stream_word_type o_copper_tx_word,            // copper data
	input wire logic            i_copper_tx_ready            // copper takes
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);

	wire cu_take = i_copper_media_pairs_valid && o_copper_media_pairs_ready && i_ce;
	wire se_in   = i_quad_mode ? i_quad_serial_rx_pair_valid : i_sgmii_rx_pair_valid;
	wire se_take = se_in && o_serial_rx_ready && i_ce;
	wire fast    = i_speed == SPEED_1000;

	a_reset_idle: assert property ($rose(i_rst_b) |-> o_copper_media_pairs_ready
		&& o_serial_rx_ready && !o_sgmii_tx_pair_valid && !o_copper_tx_valid)
		else $error("outputs not idle after reset");
	a_single_hold: assert property (o_sgmii_tx_pair_valid && !(i_sgmii_tx_pair_ready && i_ce)
		|=> o_sgmii_tx_pair_valid && $stable(o_sgmii_tx_pair_word))
		else $error("single link word dropped before taken");
	a_copper_hold: assert property (o_copper_tx_valid && !(i_copper_tx_ready && i_ce)
		|=> o_copper_tx_valid && $stable(o_copper_tx_word))
		else $error("copper word dropped before taken");
	a_freeze_ce: assert property (!i_ce |=> $stable(o_sgmii_tx_pair_valid)
		&& $stable(o_copper_tx_valid) && $stable(o_copper_media_pairs_ready))
		else $error("state moved with enable low");
	a_cu_single_lat: assert property ($rose(o_sgmii_tx_pair_valid) && fast && !i_quad_mode
		&& i_rx_lat_field == 2'h0 |-> $past(cu_take, 31)) else $error("copper to single delay");
	a_cu_single_100: assert property ($rose(o_sgmii_tx_pair_valid) && i_speed == SPEED_100
		&& !i_quad_mode && i_rx_lat_field == 2'h0 |-> $past(cu_take, 63))
		else $error("copper to single delay at 100");
	a_cu_quad_lat: assert property ($rose(o_quad_serial_tx_pair_valid) && fast && i_quad_mode
		&& i_rx_lat_field == 2'h0 |-> $past(cu_take, 32)) else $error("copper to quad delay");
	a_single_cu_lat: assert property ($rose(o_copper_tx_valid) && fast && !i_quad_mode
		&& i_tx_lat_field == 2'h0 |-> $past(se_take, 21)) else $error("single to copper delay");
	a_quad_cu_lat: assert property ($rose(o_copper_tx_valid) && fast && i_quad_mode
		&& i_tx_lat_field == 2'h0 |-> $past(se_take, 24)) else $error("quad to copper delay");

	c_single_out: cover property ($rose(o_sgmii_tx_pair_valid));
	c_quad_out: cover property ($rose(o_quad_serial_tx_pair_valid));
	c_refused: cover property (i_copper_media_pairs_valid && !o_copper_media_pairs_ready);
endmodule

bind copper_serdes_path_latency latency_path_sva i_latency_path_sva (.i_sys_clk, .i_rst_b,
	.i_ce, .i_speed, .i_quad_mode, .i_rx_lat_field, .i_tx_lat_field,
	.i_copper_media_pairs_valid, .o_copper_media_pairs_ready, .o_sgmii_tx_pair_valid,
	.o_sgmii_tx_pair_word, .i_sgmii_tx_pair_ready, .o_quad_serial_tx_pair_valid,
	.i_sgmii_rx_pair_valid, .i_quad_serial_rx_pair_valid, .o_serial_rx_ready,
	.o_copper_tx_valid, .o_copper_tx_word, .i_copper_tx_ready);

// file: testbench/tb.sv
// Purpose: self-checking bench for the latency datapath
// Assumes: far side modelled by mac_link_model
// Notes:   delay lines primed before traffic
`timescale 1ns/1ns
module tb;
	import latency_path_pkg::*;
	logic sys_clk = 1'b0, rst_b = 1'b0, ce = 1'b1, quad = 1'b0, stall = 1'b0;
	logic cu_v = 1'b0, s_v = 1'b0, q_v = 1'b0, cu_rdy = 1'b1;
	logic [1:0] rxf = 2'h0, txf = 2'h0;
	logic [3:0] pstart = 4'h0;
	speed_type speed = SPEED_1000;
	stream_word_type cu_w = '0, s_w = '0, q_w = '0, sg_w, q_ow, ct_w, wl[12];
	logic cu_ready, sg_v, q_ov, se_ready, ct_v, sg_rdy, q_rdy;
	logic [31:0] seed = 32'h7737;
	int num_errors = 0, total_checks = 0, f, i, g;
	speed_type sps[3] = '{SPEED_1000, SPEED_100, SPEED_10};

	always #5 sys_clk = ~sys_clk;

	copper_serdes_path_latency #(.DLY_AW(10)) i_copper_serdes_path_latency (
		.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_ce(ce), .i_speed(speed), .i_quad_mode(quad),
		.i_rx_lat_field(rxf), .i_tx_lat_field(txf), .i_copper_media_pairs_valid(cu_v),
		.i_copper_media_pairs_word(cu_w), .i_copper_pair_start(pstart),
		.o_copper_media_pairs_ready(cu_ready), .o_sgmii_tx_pair_valid(sg_v),
		.o_sgmii_tx_pair_word(sg_w), .i_sgmii_tx_pair_ready(sg_rdy),
		.o_quad_serial_tx_pair_valid(q_ov), .o_quad_serial_tx_pair_word(q_ow),
		.i_quad_serial_tx_pair_ready(q_rdy), .i_sgmii_rx_pair_valid(s_v),
		.i_sgmii_rx_pair_word(s_w), .i_quad_serial_rx_pair_valid(q_v),
		.i_quad_serial_rx_pair_word(q_w), .o_serial_rx_ready(se_ready),
		.o_copper_tx_valid(ct_v), .o_copper_tx_word(ct_w), .i_copper_tx_ready(cu_rdy));

	mac_link_model i_mac_link_model (.i_sys_clk(sys_clk), .i_rst_b(rst_b),
		.i_stall_en(stall), .o_sgmii_ready(sg_rdy), .o_quad_ready(q_rdy));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic int exp_lat(input bit to_cu, input bit qm, input speed_type sp, input int fl);
		int mn, st;
		case (sp)
			SPEED_1000: begin
				mn = to_cu ? (qm ? QUAD_TO_CU_1000_MIN_NS : SGMII_TO_CU_1000_MIN_NS)
					: (qm ? CU_TO_QUAD_1000_MIN_NS : CU_TO_SGMII_1000_MIN_NS);
				st = STEP_1000_NS;
			end
			SPEED_100: begin
				mn = to_cu ? (qm ? QUAD_TO_CU_100_MIN_NS : SGMII_TO_CU_100_MIN_NS)
					: (qm ? CU_TO_QUAD_100_MIN_NS : CU_TO_SGMII_100_MIN_NS);
				st = STEP_100_NS;
			end
			default: begin
				mn = to_cu ? (qm ? QUAD_TO_CU_10_MIN_NS : SGMII_TO_CU_10_MIN_NS)
					: (qm ? CU_TO_QUAD_10_MIN_NS : CU_TO_SGMII_10_MIN_NS);
				st = STEP_10_NS;
			end
		endcase
		return (mn + fl * st + 9) / 10;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		if (num_errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// one word through one path, timed from the edge that takes it
	task automatic one_path(input bit to_cu, input stream_word_type w);
		int n;
		stream_word_type got, ew;
		bit endw;
		endw = !to_cu && speed == SPEED_1000;
		ew = (endw) ? {1'b1, w.eop, w.data} : w;
		@(posedge sys_clk);
		if (!to_cu) begin cu_v <= 1'b1; cu_w <= w; end
		else if (quad) begin q_v <= 1'b1; q_w <= w; end
		else begin s_v <= 1'b1; s_w <= w; end
		@(posedge sys_clk);
		s_v <= 1'b0;
		q_v <= 1'b0;
		s_w <= ~w;
		q_w <= ~w;
		cu_w <= endw ? stream_word_type'({1'b0, 1'b1, 8'h00}) : ~w;
		cu_v <= endw;
		n = 0;
		do begin
			@(posedge sys_clk);
			cu_v <= 1'b0;
			#1;
			n++;
		end while (!(to_cu ? ct_v : (quad ? q_ov : sg_v)) && n < 800);
		got = to_cu ? ct_w : (quad ? q_ow : sg_w);
		check(32'(n), 32'(exp_lat(to_cu, quad, speed, f))); // latency
		check({22'h0, got}, {22'h0, ew}); // start flag
		for (int k = 0; k < 60 && (sg_v || q_ov || ct_v); k++) begin
			@(posedge sys_clk);
			#1;
		end
	endtask

	initial begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (1030) @(posedge sys_clk);
		for (int si = 0; si < 3; si++) begin
			for (int m = 0; m < 2; m++) begin
				// idle past both delay lines so a longer setting re-reads no old word
				repeat (700) @(posedge sys_clk);
				seed = lfsr(seed);
				f = (sps[si] == SPEED_1000) ? 0 : (m ? 3 : int'(seed[1:0]));
				speed <= sps[si];
				quad <= m[0];
				rxf <= f[1:0];
				txf <= f[1:0];
				if (sps[si] == SPEED_1000) begin
					@(posedge sys_clk) pstart <= 4'h3;
					@(posedge sys_clk) pstart <= 4'hc;
					@(posedge sys_clk) pstart <= 4'h0;
				end
				one_path(1'b1, {2'b10, seed[11:4]});
				if (sps[si] != SPEED_10) begin
					one_path(1'b0, {2'b00, seed[19:12]});
				end
			end
		end
		// nibbles join after the delimiter; the trailing half byte is dropped
		for (int k = 0; k < 7; k++) begin
			@(posedge sys_clk);
			cu_v <= k < 6;
			cu_w <= {1'b0, k == 5, 4'h0, 4'(20'h7a3d5 >> (4 * k))};
		end
		g = 0;
		while (!q_ov && g < 800) begin
			@(posedge sys_clk);
			#1;
			g++;
		end
		check({22'h0, q_ow}, 32'h2a3); // first byte
		repeat (2) @(posedge sys_clk);
		#1;
		check({22'h0, q_ow}, 32'h100); // end word
		// burst at 100 with stalls and enable gaps; nothing lost
		speed <= SPEED_100;
		quad <= 1'b0;
		rxf <= 2'h1;
		stall <= 1'b1;
		for (int k = 0; k < 12; k++) begin
			seed = lfsr(seed);
			wl[k] = seed[9:0];
		end
		i = 0;
		g = 0;
		@(posedge sys_clk);
		cu_v <= 1'b1;
		cu_w <= wl[0];
		for (int k = 0; k < 4000 && g < 12; k++) begin
			// handshakes judged on values that stand up to the next edge
			@(negedge sys_clk);
			if (sg_v && sg_rdy && ce) begin
				check({22'h0, sg_w}, {22'h0, wl[g]}); // order
				g++;
			end
			i += int'(cu_v && cu_ready && ce);
			@(posedge sys_clk);
			cu_v <= i < 12;
			cu_w <= wl[i % 12];
			seed = lfsr(seed);
			ce <= seed[2:0] != 3'h0;
		end
		check(32'(g), 32'd12); // count
		end_of_test;
	end

	initial begin
		#(800000);
		num_errors++;
		end_of_test;
	end
endmodule
